// [pkg/drpc_map.vh]
/*
 Register map constants for the row population and timing block.
 Assumes inclusion by bare name from design files; definitions only.
*/
`ifndef DRPC_MAP_VH
`define DRPC_MAP_VH
// Avalon word addresses (printed offsets are not multiples of four)
`define DRPC_ADDR_W          8
`define DRPC_IDX_POP         8'h52
`define DRPC_IDX_TIMING      8'h53
`define DRPC_IDX_LOCK        8'h54
`define DRPC_IDX_ROW0        8'h55
`define DRPC_IDX_ROW1        8'h56
`define DRPC_IDX_ROW2        8'h57
`define DRPC_IDX_ROW3        8'h58
`define DRPC_POP_RESET       8'h00
`define DRPC_TIMING_RESET    8'h00
`define DRPC_TIMING_WMASK    8'hf7
// Field positions
`define DRPC_POP_D1_HI       7
`define DRPC_POP_D1_LO       4
`define DRPC_POP_D0_HI       3
`define DRPC_POP_D0_LO       0
`define DRPC_MODE_HI         7
`define DRPC_MODE_LO         5
`define DRPC_CYCLE_BIT       4
`define DRPC_CAS_BIT         2
`define DRPC_RCD_BIT         1
`define DRPC_RP_BIT          0
// Mode select encodings
`define DRPC_MODE_SELF       3'h0
`define DRPC_MODE_NORM1      3'h1
`define DRPC_MODE_NORM2      3'h2
`define DRPC_MODE_NORM3      3'h3
`define DRPC_MODE_NOP        3'h4
`define DRPC_MODE_PREALL     3'h5
`define DRPC_MODE_MRS        3'h6
`define DRPC_MODE_REFRESH    3'h7
// Geometry
`define DRPC_ROWS            6
`define DRPC_ROW_DATA_W      64
`define DRPC_CODE_EMPTY      4'h0
`define DRPC_CODE_DS_MASK    16'hb8da
`endif

// [logic/drpc_decode.v]
/*
 Decodes one four-bit population code into capacity and geometry.
 Assumes a purely combinational context; caller registers results.
*/
`timescale 1ns/100ps
`include "drpc_map.vh"
module drpc_decode (
    input  wire [3:0] code,        // Population code
    output reg        present,     // Slot populated
    output reg        double_side, // Back side populated
    output reg  [9:0] capacity_mb, // Module size in MB
    output reg  [3:0] row_bits,    // Row address width
    output reg  [1:0] bank_bits,   // Bank address width
    output reg  [3:0] col_bits     // Column address width (front side)
);
    // One bit per code, set where the module has a back side
    localparam [15:0] ds_mask = `DRPC_CODE_DS_MASK;

    // Code table lookup
    always @* begin
        present     = (code != `DRPC_CODE_EMPTY);
        double_side = ds_mask[code];
        row_bits    = 4'hc;
        bank_bits   = 2'h2;
        col_bits    = 4'h8;
        capacity_mb = 10'h000;
        case (code)
            4'h1: begin capacity_mb = 10'h020; row_bits = 4'hb; bank_bits = 2'h1; col_bits = 4'h9; end
            4'h2: begin capacity_mb = 10'h020; end
            4'h3: begin capacity_mb = 10'h030; end
            4'h4: begin capacity_mb = 10'h040; end
            4'h5: begin capacity_mb = 10'h040; col_bits = 4'h9; end
            4'h6: begin capacity_mb = 10'h060; col_bits = 4'h9; end
            4'h7: begin capacity_mb = 10'h080; col_bits = 4'h9; end
            4'h9: begin capacity_mb = 10'h080; col_bits = 4'ha; end
            4'ha: begin capacity_mb = 10'h080; row_bits = 4'hd; col_bits = 4'h9; end
            4'hb: begin capacity_mb = 10'h0c0; col_bits = 4'ha; end
            4'hc: begin capacity_mb = 10'h100; col_bits = 4'ha; end
            4'hd: begin capacity_mb = 10'h100; row_bits = 4'hd; col_bits = 4'h9; end
            4'he: begin capacity_mb = 10'h100; row_bits = 4'hd; col_bits = 4'ha; end
            4'hf: begin capacity_mb = 10'h200; row_bits = 4'hd; col_bits = 4'ha; end
            default: begin row_bits = 4'h0; bank_bits = 2'h0; col_bits = 4'h0; end
        endcase
    end
endmodule

// [logic/drpc_top.v]
/*
 Row population and timing mode registers of an SDRAM controller,
 reached over Avalon-MM with waitrequest. Assumes one 100 MHz clock and
 a config lock level from logic on the same clock.
*/
// Summary of operation
// RULE1 - Six rows over three DIMM slots; only slots 0 and 1 are decoded, rows 4 and 5 are held at 0
// RULE2 - Each row has a 64-bit data path
// RULE3 - Population at 52h, reset 00h, lock freezes
// RULE4 - Software slows 133 MHz clock when overpopulated
// RULE5 - Slot one code high nibble, slot zero low
// RULE6 - Decode codes into size and geometry
// RULE7 - Timing at 53h, reset 00h, fields defined
// RULE8 - Mode select default self-refresh; special commands
// RULE9 - Slot n front row 2n, back 2n+1
`timescale 1ns/100ps
`include "drpc_map.vh"
module drpc_top (
    input  wire        clk,              // 100 MHz clock
    input  wire        reset,            // Synchronous, active high
    input  wire        config_lock_bit,  // Lock from another register
    input  wire [7:0]  avs_address,      // Word address
    input  wire        avs_read,         // Read strobe
    input  wire        avs_write,        // Write strobe
    input  wire [3:0]  avs_byteenable,   // Byte enables
    input  wire [31:0] avs_writedata,    // Write data
    output reg  [31:0] avs_readdata,     // Read data
    output reg         avs_waitrequest,  // Stall until answer
    output reg  [5:0]  row_enable,       // Populated physical rows
    output reg  [2:0]  sdram_operation_select, // Current mode field
    output reg         refresh_enable,   // Normal refresh running
    output reg  [1:0]  refresh_rate,     // Interval step, 1..3
    output reg  [1:0]  cpu_cmd_override, // 0 none,1 NOP,2 precharge,3 MRS
    output reg         cpu_cmd_refresh,  // Processor cycles give refresh
    output reg         access_cycle_length, // Cycle time bit
    output reg         cas_latency,      // CAS latency bit
    output reg         ras_to_cas,       // RAS to CAS delay bit
    output reg         ras_precharge,    // RAS precharge bit
    output reg  [10:0] total_mb          // Installed memory size
);
    reg  [7:0] dimm_row_population;
    reg  [7:0] memory_timing_mode;
    reg        answered;
    reg [31:0] next_readdata;
    wire       access = avs_read | avs_write;
    // Writes land only at the edge where waitrequest is seen low
    wire       wr_go  = avs_write & ~avs_waitrequest & avs_byteenable[0];

    // Per-slot decode; slot 2 is outside this register and seen empty
    wire [1:0] present;
    wire [1:0] dside;
    wire [19:0] cap;
    wire [15:0] rowb;
    wire [7:0]  bankb;
    wire [15:0] colb;
    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : slot
            drpc_decode u_dec (
                .code        (dimm_row_population[4*g+3:4*g]), // RULE5
                .present     (present[g]),
                .double_side (dside[g]),
                .capacity_mb (cap[10*g+9:10*g]),
                .row_bits    (rowb[4*g+3:4*g]),
                .bank_bits   (bankb[2*g+1:2*g]),
                .col_bits    (colb[4*g+3:4*g])
            ); // RULE6
        end
    endgenerate

    // Bus handshake: one wait cycle, then answer
    always @(posedge clk) begin
        if (reset) begin
            avs_waitrequest <= 1'b1;
            answered        <= 1'b0;
            avs_readdata    <= 32'h00000000;
        end else begin
            answered        <= access & ~answered;
            avs_waitrequest <= ~(access & ~answered);
            avs_readdata    <= next_readdata;
        end
    end

    // Read mux; unmapped addresses read zero
    always @* begin
        next_readdata = 32'h00000000;
        case (avs_address)
            `DRPC_IDX_POP:    next_readdata[7:0] = dimm_row_population;
            `DRPC_IDX_TIMING: next_readdata[7:0] = memory_timing_mode & `DRPC_TIMING_WMASK;
            `DRPC_IDX_LOCK:   next_readdata[0]   = config_lock_bit;
            `DRPC_IDX_ROW0:   next_readdata      = {12'h000, rowb[7:4], colb[7:4], bankb[3:2],
                                                    rowb[3:0], colb[3:0], bankb[1:0]};
            `DRPC_IDX_ROW1:   next_readdata      = {12'h000, cap[19:10], cap[9:0]};
            `DRPC_IDX_ROW2:   next_readdata      = {26'h0000000, row_enable};
            `DRPC_IDX_ROW3:   next_readdata      = {21'h000000, total_mb};
            default:          next_readdata      = 32'h00000000;
        endcase
    end

    // Register writes, taken on the edge the answer is given
    always @(posedge clk) begin
        if (reset) begin
            dimm_row_population <= `DRPC_POP_RESET; // RULE3
            memory_timing_mode  <= `DRPC_TIMING_RESET; // RULE7
        end else if (wr_go) begin
            if (avs_address == `DRPC_IDX_POP && !config_lock_bit)
                dimm_row_population <= avs_writedata[7:0]; // RULE3
            if (avs_address == `DRPC_IDX_TIMING)
                memory_timing_mode <= avs_writedata[7:0] & `DRPC_TIMING_WMASK; // RULE7
        end
    end

    // Row enables: slot n front is row 2n, back is 2n+1
    always @(posedge clk) begin
        if (reset) begin
            row_enable <= 6'h00;
            total_mb   <= 11'h000;
        end else begin
            row_enable <= {2'h0, present[1] & dside[1], present[1],
                           present[0] & dside[0], present[0]}; // RULE9 RULE1
            total_mb   <= {1'b0, cap[19:10]} + {1'b0, cap[9:0]}; // RULE2
        end
    end

    // Mode field decode into refresh and command overrides
    always @(posedge clk) begin
        if (reset) begin
            sdram_operation_select <= `DRPC_MODE_SELF;
            refresh_enable         <= 1'b0;
            refresh_rate           <= 2'h0;
            cpu_cmd_override       <= 2'h0;
            cpu_cmd_refresh        <= 1'b0;
            access_cycle_length    <= 1'b0;
            cas_latency            <= 1'b0;
            ras_to_cas             <= 1'b0;
            ras_precharge          <= 1'b0;
        end else begin
            sdram_operation_select <= memory_timing_mode[`DRPC_MODE_HI:`DRPC_MODE_LO];
            access_cycle_length    <= memory_timing_mode[`DRPC_CYCLE_BIT]; // RULE7
            cas_latency            <= memory_timing_mode[`DRPC_CAS_BIT];
            ras_to_cas             <= memory_timing_mode[`DRPC_RCD_BIT];
            ras_precharge          <= memory_timing_mode[`DRPC_RP_BIT];
            refresh_enable         <= 1'b0;
            refresh_rate           <= 2'h0;
            cpu_cmd_override       <= 2'h0;
            cpu_cmd_refresh        <= 1'b0;
            case (memory_timing_mode[`DRPC_MODE_HI:`DRPC_MODE_LO])
                `DRPC_MODE_NORM1:   begin refresh_enable <= 1'b1; refresh_rate <= 2'h1; end // RULE8
                `DRPC_MODE_NORM2:   begin refresh_enable <= 1'b1; refresh_rate <= 2'h2; end
                `DRPC_MODE_NORM3:   begin refresh_enable <= 1'b1; refresh_rate <= 2'h3; end
                `DRPC_MODE_NOP:     cpu_cmd_override <= 2'h1;
                `DRPC_MODE_PREALL:  cpu_cmd_override <= 2'h2;
                `DRPC_MODE_MRS:     cpu_cmd_override <= 2'h3;
                `DRPC_MODE_REFRESH: cpu_cmd_refresh  <= 1'b1;
                default:            refresh_enable   <= 1'b0; // Self-refresh
            endcase
        end
    end
endmodule

// [testbench/drpc_props.sv]
/* Port checker for the row population and timing block.
 Assumes one clock and the synchronous reset. */
`timescale 1ns/100ps
module drpc_props (
    input wire        clk,                    // Block clock
    input wire        reset,                  // Synchronous, active high
    input wire        config_lock_bit,        // Population lock level
    input wire [7:0]  avs_address,            // Word address
    input wire        avs_read,               // Read strobe
    input wire        avs_write,              // Write strobe
    input wire        avs_waitrequest,        // Stall until answer
    input wire [31:0] avs_readdata,           // Read data
    input wire [5:0]  row_enable,             // Populated physical rows
    input wire [2:0]  sdram_operation_select, // Mode field copy
    input wire        refresh_enable,         // Normal refresh running
    input wire [1:0]  refresh_rate,           // Interval step
    input wire [1:0]  cpu_cmd_override,       // Processor command override
    input wire        cpu_cmd_refresh,        // Processor cycles give refresh
    input wire        cas_latency,            // CAS latency bit
    input wire [10:0] total_mb                // Installed memory size
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    // Answer and locked-write events
    sequence rd_ans(a); avs_read && !avs_waitrequest && avs_address == a; endsequence
    sequence locked_wr; avs_write && !avs_waitrequest && avs_address == 8'h52 && config_lock_bit; endsequence
    wire [2:0] sel = sdram_operation_select;
    a_wait_answer: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
        else $error("request not answered after one wait cycle");
    a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("answer held longer than one cycle");
    a_reset_clear: assert property (disable iff (1'b0) reset |=> avs_waitrequest && row_enable == 6'h00
        && sel == 3'h0 && total_mb == 11'h000) else $error("outputs not cleared by reset");
    a_pop_rows: assert property (rd_ans(8'h52) |-> row_enable[5:4] == 2'h0 && avs_readdata[31:8] == 24'h0
        && row_enable[0] == (|avs_readdata[3:0]) && row_enable[2] == (|avs_readdata[7:4]))
        else $error("front rows disagree with population");
    a_lock_freeze: assert property (locked_wr |-> ##2 $stable(row_enable))
        else $error("locked population write changed rows");
    a_timing_read: assert property (rd_ans(8'h53) |-> avs_readdata[3] == 1'b0
        && sel == avs_readdata[7:5] && cas_latency == avs_readdata[2]) else $error("timing readback mismatch");
    a_refresh_modes: assert property (refresh_enable == (sel != 3'h0 && !sel[2])
        && refresh_rate == (refresh_enable ? sel[1:0] : 2'h0)) else $error("refresh decode wrong");
    a_cmd_modes: assert property (cpu_cmd_refresh == (sel == 3'h7)
        && cpu_cmd_override == ((sel[2] && !cpu_cmd_refresh) ? sel[1:0] + 2'h1 : 2'h0))
        else $error("processor command decode wrong");
endmodule
bind drpc_top drpc_props u_props (.clk(clk), .reset(reset), .config_lock_bit(config_lock_bit),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
    .avs_readdata(avs_readdata), .row_enable(row_enable), .sdram_operation_select(sdram_operation_select),
    .refresh_enable(refresh_enable), .refresh_rate(refresh_rate), .cpu_cmd_override(cpu_cmd_override),
    .cpu_cmd_refresh(cpu_cmd_refresh), .cas_latency(cas_latency), .total_mb(total_mb));

// [testbench/drpc_dimm_model.sv]
/* Memory side model: one 64-bit lane per populated row.
 Assumes row_enable comes from the controller. */
`timescale 1ns/100ps
module drpc_dimm_model (
    input  wire [5:0] row_enable, // Rows with a module side
    output reg  [9:0] lane_bits   // Data bits wired up
);
    integer i;
    // Six rows at most, each adds 64 bits
    always @* begin
        lane_bits = 10'h000;
        for (i = 0; i < 6; i = i + 1)
            lane_bits = lane_bits + {3'h0, row_enable[i], 6'h00};
    end
endmodule

// [testbench/tb_drpc_top.sv]
/* Testbench for the row population and timing block.
 Assumes the Avalon answer after one wait cycle. */
`timescale 1ns/100ps
`define CHK(g, e) begin n_compared = n_compared + 1; if ((g) !== (e)) begin n_mismatch = n_mismatch + 1; \
    $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module tb_drpc_top;
    reg         clk, reset, config_lock_bit, avs_read, avs_write;
    reg  [7:0]  avs_address;
    reg  [3:0]  avs_byteenable;
    reg  [31:0] avs_writedata, q;
    wire [31:0] avs_readdata;
    wire        avs_waitrequest, refresh_enable, cpu_cmd_refresh, access_cycle_length, cas_latency, ras_to_cas;
    wire        ras_precharge;
    wire [5:0]  row_enable;
    wire [2:0]  sdram_operation_select;
    wire [1:0]  refresh_rate, cpu_cmd_override;
    wire [10:0] total_mb;
    wire [9:0]  lane_bits;
    wire [6:0]  timing_out = {sdram_operation_select, access_cycle_length, cas_latency, ras_to_cas, ras_precharge};
    integer     n_mismatch = 0, n_compared = 0, c;
    reg  [15:0] ds = 16'hb8da; // Double-sided codes
    reg [159:0] caps = {10'h200, 10'h100, 10'h100, 10'h100, 10'h0c0, 10'h080, 10'h080, 10'h000,
                        10'h080, 10'h060, 10'h040, 10'h040, 10'h030, 10'h020, 10'h020, 10'h000};
    drpc_top DUT (.clk(clk), .reset(reset), .config_lock_bit(config_lock_bit), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(avs_byteenable),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .row_enable(row_enable), .sdram_operation_select(sdram_operation_select),
        .refresh_enable(refresh_enable), .refresh_rate(refresh_rate), .cpu_cmd_override(cpu_cmd_override),
        .cpu_cmd_refresh(cpu_cmd_refresh), .access_cycle_length(access_cycle_length),
        .cas_latency(cas_latency), .ras_to_cas(ras_to_cas), .ras_precharge(ras_precharge), .total_mb(total_mb));
    drpc_dimm_model u_dimm (.row_enable(row_enable), .lane_bits(lane_bits));
    // Bus write, held until waitrequest low
    task wr(input [7:0] a, input [7:0] d, input [3:0] be);
        begin
            avs_address <= a; avs_writedata <= {24'h0, d}; avs_byteenable <= be; avs_write <= 1'b1;
            @(posedge clk);
            while (avs_waitrequest !== 1'b0) @(posedge clk);
            avs_write <= 1'b0;
            @(posedge clk);
        end
    endtask
    // Bus read, data taken at the answering edge
    task rd(input [7:0] a, output [31:0] d);
        begin
            avs_address <= a; avs_read <= 1'b1;
            @(posedge clk);
            while (avs_waitrequest !== 1'b0) @(posedge clk);
            d = avs_readdata;
            avs_read <= 1'b0;
            @(posedge clk);
        end
    endtask
    task summarize;
        begin
            $display("compared %0d mismatches %0d", n_compared, n_mismatch);
            if (n_mismatch == 0 && n_compared > 0)
                $display("Simulation passed");
            else
                $display("Simulation failed");
            $finish;
        end
    endtask
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Watchdog well beyond the expected run
    initial begin
        #200000;
        n_mismatch = n_mismatch + 1;
        summarize;
    end
    initial begin
        reset = 1'b1; config_lock_bit = 1'b0; avs_read = 1'b0; avs_write = 1'b0;
        avs_address = 8'h00; avs_byteenable = 4'h0; avs_writedata = 32'h0;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        rd(8'h52, q); `CHK(q, 32'h0)
        rd(8'h53, q); `CHK(q, 32'h0)
        wr(8'h52, 8'h5a, 4'h1); rd(8'h52, q); `CHK(q, 32'h5a)
        `CHK({row_enable, total_mb}, {6'h05, 11'h0c0})
        // Every population code in both slots
        for (c = 0; c < 16; c = c + 1) begin
            wr(8'h52, {c[3:0], c[3:0]}, 4'h1); rd(8'h52, q); `CHK(q, {24'h0, c[3:0], c[3:0]})
            `CHK(row_enable, {2'b00, ds[c], c != 0, ds[c], c != 0})
            `CHK(total_mb, {caps[c*10 +: 10], 1'b0})
        end
        `CHK(lane_bits, 10'h100)
        // Two double-sided modules sit at the limit; software keeps the clock
        rd(8'h52, q);
        `CHK(q, 32'hff)
        config_lock_bit <= 1'b1;
        wr(8'h52, 8'h12, 4'h1); rd(8'h52, q); `CHK(q, 32'hff)
        // Timing stays writable while locked
        for (c = 0; c < 8; c = c + 1) begin
            wr(8'h53, {c[2:0], 5'h1f}, 4'h1); rd(8'h53, q); `CHK(q, {24'h0, c[2:0], 5'h17})
            `CHK(timing_out, {c[2:0], 4'hf})
        end
        config_lock_bit <= 1'b0;
        wr(8'h52, 8'h21, 4'h1); wr(8'h52, 8'h00, 4'h0); rd(8'h52, q); `CHK(q, 32'h21)
        `CHK({row_enable, total_mb}, {6'h07, 11'h040})
        wr(8'h60, 8'hff, 4'hf); rd(8'h60, q); `CHK(q, 32'h0)
        reset <= 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        rd(8'h52, q); `CHK(q, 32'h0)
        rd(8'h53, q); `CHK(q, 32'h0)
        summarize;
    end
endmodule
